// ---- rtl/ssb_pkg.sv ----
// shared constants for the burst sram pair
package ssb_pkg;

   // ********************
   // data and address shape
   // ********************
   localparam int LANES  = 4;
   localparam int LANE_W = 9;
   localparam int DATA_W = LANES * LANE_W;
   localparam int ADDR_W = 8;
   localparam int HI_W   = DATA_W - 32;

   // ********************
   // sleep pipeline, in cycles
   // ********************
   localparam int SLEEP_ENTER_CYC = 2;
   localparam int SLEEP_EXIT_CYC  = 2;

   // ********************
   // controller register map
   // ********************
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_CMD      = 8'h04;
   localparam logic [7:0] REG_ADDR     = 8'h08;
   localparam logic [7:0] REG_WDATA    = 8'h0c;
   localparam logic [7:0] REG_WDATA_HI = 8'h10;
   localparam logic [7:0] REG_RDATA    = 8'h14;
   localparam logic [7:0] REG_RDATA_HI = 8'h18;
   localparam logic [7:0] REG_STATUS   = 8'h1c;

   // ctrl fields
   localparam int CTRL_ORDER = 0;
   localparam int CTRL_PIPE  = 1;
   localparam int CTRL_SLEEP = 2;
   localparam int CTRL_OE_N  = 3;
   localparam int CTRL_HOLD  = 4;
   localparam logic [4:0] CTRL_RST = 5'h02;

   // cmd fields
   localparam int CMD_KIND  = 0;
   localparam int CMD_BEATS = 2;
   localparam int CMD_BE    = 4;
   localparam logic [1:0] KIND_READ  = 2'h0;
   localparam logic [1:0] KIND_WRITE = 2'h1;
   localparam logic [1:0] KIND_DESEL = 2'h2;

   // status fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;

   typedef enum logic [1:0] {OP_DESEL, OP_READ, OP_WRITE} ssb_op_t;

   // low two address bits of a burst beat
   function automatic logic [1:0] ssb_burst_low(
      input logic [1:0] start,
      input logic [1:0] step,
      input logic       ilv);
      return ilv ? (start ^ step) : 2'(start + step);
   endfunction

endpackage

// ---- rtl/ssb_if.sv ----
// pin-level link between burst sram and its controller
`timescale 1ns/100ps
interface ssb_if #(
   parameter int ADDR_W = ssb_pkg::ADDR_W
) ();
   localparam int DW = ssb_pkg::DATA_W;

   // ********************
   // controller driven pins
   // ********************
   logic                      cke_n;
   logic                      load_advance;
   logic                      write_n;
   logic [ssb_pkg::LANES-1:0] byte_lane_write_n;
   logic                      select_first_n;
   logic                      select_second;
   logic                      select_third_n;
   logic                      out_enable_n;
   logic                      sleep_request;
   logic                      burst_order_select;
   logic                      output_register_mode;
   logic [ADDR_W-1:0]         addr;

   // ********************
   // shared data bus
   // ********************
   logic [DW-1:0]             dev_dq_o;
   logic                      dev_dq_oe;
   logic [DW-1:0]             host_dq_o;
   logic                      host_dq_oe;
   logic                      dev_drives;
   logic [DW-1:0]             dq;

   // oe and sleep mask drivers unclocked
   assign dev_drives = dev_dq_oe & ~out_enable_n & ~sleep_request;
   assign dq = dev_drives ? dev_dq_o : (host_dq_oe ? host_dq_o : '0);

   modport dev (
      input  cke_n, load_advance, write_n, byte_lane_write_n,
      input  select_first_n, select_second, select_third_n,
      input  out_enable_n, sleep_request, burst_order_select,
      input  output_register_mode, addr, dq,
      output dev_dq_o, dev_dq_oe
   );

   modport host (
      output cke_n, load_advance, write_n, byte_lane_write_n,
      output select_first_n, select_second, select_third_n,
      output out_enable_n, sleep_request, burst_order_select,
      output output_register_mode, addr,
      output host_dq_o, host_dq_oe,
      input  dq
   );
endinterface

// ---- rtl/ssb_dev.sv ----
// synchronous burst sram end: command decode, burst counter, data pipe
// How it works
// (R1) clock enable high freezes all state but the sleep delay, status flags and drive_r, which sleep still clears
// (R2) pins sampled on rising edge, except asynchronous ones
// (R3) selected only with all three enables active
// (R4) low byte enables write lanes; none aborts
// (R5) load with write high starts read
// (R6) pipelined read data leaves one edge later
// (R7) pipelined write data due at third edge
// (R8) flow-through read data follows address edge
// (R9) flow-through write data due at second edge
// (R10) advance steps counter, ignores enables and write
// (R11) load low takes start address from pins
// (R12) counter wraps after four addresses
// (R13) order input low linear, high interleaved
// (R14) linear adds step, interleaved xors step
// (R15) drivers off during writes automatically
// (R16) output enable high makes read dummy
// (R17) deselect continue only after deselect, undriven
// (R18) stall keeps read driven, write undriven
// (R19) sleep high ignores commands, floats outputs
// (R20) sleep enters and leaves two cycles later
// (R21) register mode low flow-through, else pipelined
// (R22) outputs float from power-up until read
`timescale 1ns/100ps
module ssb_dev #(
   parameter int ADDR_W = ssb_pkg::ADDR_W
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // pin side
   ssb_if.dev        bus,
   // status side
   output logic      asleep,
   output logic      access
);

   localparam int LANES = ssb_pkg::LANES;
   localparam int LW    = ssb_pkg::LANE_W;
   localparam int DW    = ssb_pkg::DATA_W;
   localparam int DEPTH = 1 << ADDR_W;

   // ************************************************************
   // storage
   // ************************************************************
   logic [DW-1:0]       mem [DEPTH];

   // ************************************************************
   // state
   // ************************************************************
   logic                zz_p1_r;
   logic                zz_p2_r;
   logic                asleep_r;
   logic                access_r;
   ssb_pkg::ssb_op_t    op_r;
   logic [ADDR_W-1:0]   base_r;
   logic [1:0]          step_r;
   logic                s1_rd_r;
   logic                s1_wr_r;
   logic [ADDR_W-1:0]   s1_addr_r;
   logic [LANES-1:0]    s1_be_r;
   logic [DW-1:0]       s1_q_r;
   logic                s2_wr_r;
   logic [ADDR_W-1:0]   s2_addr_r;
   logic [LANES-1:0]    s2_be_r;
   logic [DW-1:0]       dq_r;
   logic                drive_r;

   // ************************************************************
   // decode
   // ************************************************************
   logic                live;
   logic                flow;
   logic                selected;
   logic                sleeping;
   ssb_pkg::ssb_op_t    op_nxt;
   logic [ADDR_W-1:0]   base_nxt;
   logic [1:0]          step_nxt;
   logic [ADDR_W-1:0]   acc_addr;
   logic                rd_now;
   logic                wr_now;
   logic                cmt_wr;
   logic [ADDR_W-1:0]   cmt_addr;
   logic [LANES-1:0]    cmt_be;

   // sleep pin and the delayed sleep both kill commands
   assign sleeping = bus.sleep_request | zz_p2_r;             // (R19)
   assign live     = ~bus.cke_n & ~sleeping;                  // (R1)
   assign flow     = ~bus.output_register_mode;               // (R21)
   assign selected = ~bus.select_first_n & bus.select_second
                   & ~bus.select_third_n;                     // (R3)

   always_comb
   begin
      op_nxt   = ssb_pkg::OP_DESEL;
      base_nxt = base_r;
      step_nxt = step_r;
      acc_addr = bus.addr;
      if (!bus.load_advance)
      begin
         base_nxt = bus.addr;                                 // (R11)
         step_nxt = 2'h0;
         if (selected)
         begin
            op_nxt = bus.write_n ? ssb_pkg::OP_READ           // (R5)
                                 : ssb_pkg::OP_WRITE;
         end
      end
      else
      begin
         // enables and write pin are don't-care while advancing
         op_nxt   = op_r;                                     // (R10)
         step_nxt = 2'(step_r + 2'h1);                        // (R12)
         acc_addr = {base_r[ADDR_W-1:2],
                     ssb_pkg::ssb_burst_low(base_r[1:0], step_nxt,
                        bus.burst_order_select)};             // (R13) (R14)
      end
   end

   // a continue after deselect stays deselected
   assign rd_now = (op_nxt == ssb_pkg::OP_READ);              // (R17)
   assign wr_now = (op_nxt == ssb_pkg::OP_WRITE);

   // late write: flow takes data one edge on, pipelined two
   assign cmt_wr   = flow ? s1_wr_r   : s2_wr_r;              // (R7) (R9)
   assign cmt_addr = flow ? s1_addr_r : s2_addr_r;
   assign cmt_be   = flow ? s1_be_r   : s2_be_r;

   // ************************************************************
   // sleep delay
   // ************************************************************
   // first stage only feeds the second; pin is asynchronous
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         zz_p1_r <= 1'b0;
         zz_p2_r <= 1'b0;
      end
      else
      begin
         zz_p1_r <= bus.sleep_request;                        // (R20)
         zz_p2_r <= zz_p1_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         asleep_r <= 1'b0;
         access_r <= 1'b0;
      end
      else
      begin
         asleep_r <= zz_p2_r;
         access_r <= live & (rd_now | wr_now);
      end
   end

   // ************************************************************
   // command and burst counter
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         op_r   <= ssb_pkg::OP_DESEL;
         base_r <= '0;
         step_r <= 2'h0;
      end
      else if (live)                                          // (R1) (R2)
      begin
         op_r   <= op_nxt;
         base_r <= base_nxt;
         step_r <= step_nxt;
      end
   end

   // ************************************************************
   // access pipeline
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_rd_r   <= 1'b0;
         s1_wr_r   <= 1'b0;
         s1_addr_r <= '0;
         s1_be_r   <= '1;
         s1_q_r    <= '0;
         s2_wr_r   <= 1'b0;
         s2_addr_r <= '0;
         s2_be_r   <= '1;
      end
      else if (live)
      begin
         s1_rd_r   <= rd_now;
         s1_wr_r   <= wr_now;
         s1_addr_r <= acc_addr;
         // lane mask follows each beat, so a beat may abort alone
         s1_be_r   <= bus.byte_lane_write_n;                  // (R4)
         s1_q_r    <= mem[acc_addr];                          // (R6)
         s2_wr_r   <= s1_wr_r;
         s2_addr_r <= s1_addr_r;
         s2_be_r   <= s1_be_r;
      end
   end

   // write through only the lanes whose enable is low
   always_ff @(posedge pclk)
   begin
      if (live & cmt_wr)
      begin
         for (int i = 0; i < LANES; i++)
         begin
            if (!cmt_be[i])                                   // (R4)
            begin
               mem[cmt_addr][i*LW +: LW] <= bus.dq[i*LW +: LW];
            end
         end
      end
   end

   // ************************************************************
   // output drivers
   // ************************************************************
   // a stalled edge leaves drive_r alone, so a read keeps the bus
   // and a write slot keeps it released
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dq_r    <= '0;
         drive_r <= 1'b0;                                     // (R22)
      end
      else if (sleeping)
      begin
         drive_r <= 1'b0;                                     // (R19)
      end
      else if (live)                                          // (R18)
      begin
         if (flow)
         begin
            drive_r <= rd_now;                                // (R8) (R15)
            if (rd_now)
            begin
               dq_r <= mem[acc_addr];
            end
         end
         else
         begin
            drive_r <= s1_rd_r;                               // (R6) (R15)
            if (s1_rd_r)
            begin
               dq_r <= s1_q_r;
            end
         end
      end
   end

   // output enable gating sits in the link, not here
   assign bus.dev_dq_o  = dq_r;                               // (R16)
   assign bus.dev_dq_oe = drive_r;
   assign asleep        = asleep_r;
   assign access        = access_r;

endmodule // ssb_dev

// ---- rtl/ssb_host.sv ----
// controller end: apb registers turned into sram pin sequences
`timescale 1ns/100ps
module ssb_host #(
   parameter int ADDR_W = ssb_pkg::ADDR_W
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // pin side
   ssb_if.host              bus
);

   localparam int DW    = ssb_pkg::DATA_W;
   localparam int HW    = ssb_pkg::HI_W;
   localparam int LANES = ssb_pkg::LANES;

   logic [4:0]         ctrl_r;
   logic [ADDR_W-1:0]  addr_r;
   logic [DW-1:0]      wdata_r;
   logic [DW-1:0]      rdata_r;
   logic               done_r;
   logic [31:0]        prdata_r;
   logic               pready_r;
   logic               pslverr_r;
   logic               la_r;
   logic               wn_r;
   logic               s1n_r;
   logic [LANES-1:0]   be_r;
   logic [ADDR_W-1:0]  caddr_r;
   logic [1:0]         beats_r;
   logic               act_rd_r;
   logic               act_wr_r;
   logic               p1_rd_r;
   logic               p1_wr_r;
   logic               p2_rd_r;
   logic               p2_wr_r;
   logic               hoe_r;
   logic [DW-1:0]      hdq_r;

   logic               wr_acc;
   logic               busy;
   logic               flow;
   logic               run;
   logic               issue;
   logic               capture;
   logic [1:0]         kind;

   assign wr_acc  = psel & penable & pwrite & pready_r;
   assign busy    = act_rd_r | act_wr_r | p1_rd_r | p1_wr_r
                  | p2_rd_r | p2_wr_r;
   assign flow    = ~ctrl_r[ssb_pkg::CTRL_PIPE];
   assign run     = ~ctrl_r[ssb_pkg::CTRL_HOLD];
   // commands arriving while busy are dropped
   assign issue   = wr_acc & (paddr == ssb_pkg::REG_CMD) & ~busy;
   assign kind    = pwdata[ssb_pkg::CMD_KIND +: 2];
   assign capture = run & (flow ? p1_rd_r : p2_rd_r);

   // ************************************************************
   // apb slave, zero wait
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r  <= 32'h0;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else
      begin
         pready_r <= 1'b1;
         if (psel & ~penable)
         begin
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
            unique case (paddr)
               ssb_pkg::REG_CTRL:     prdata_r <= {27'h0, ctrl_r};
               ssb_pkg::REG_ADDR:     prdata_r <= 32'(addr_r);
               ssb_pkg::REG_WDATA:    prdata_r <= wdata_r[31:0];
               ssb_pkg::REG_WDATA_HI: prdata_r <= 32'(wdata_r[DW-1:32]);
               ssb_pkg::REG_RDATA:    prdata_r <= rdata_r[31:0];
               ssb_pkg::REG_RDATA_HI: prdata_r <= 32'(rdata_r[DW-1:32]);
               ssb_pkg::REG_STATUS:   prdata_r <= {30'h0, done_r, busy};
               ssb_pkg::REG_CMD:      prdata_r <= 32'h0;
               default:               pslverr_r <= 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r  <= ssb_pkg::CTRL_RST;
         addr_r  <= '0;
         wdata_r <= '0;
      end
      else if (wr_acc)
      begin
         if (paddr == ssb_pkg::REG_CTRL)
            ctrl_r <= pwdata[4:0];
         if (paddr == ssb_pkg::REG_ADDR)
            addr_r <= pwdata[ADDR_W-1:0];
         if (paddr == ssb_pkg::REG_WDATA)
            wdata_r[31:0] <= pwdata;
         if (paddr == ssb_pkg::REG_WDATA_HI)
            wdata_r[DW-1:32] <= pwdata[HW-1:0];
      end
   end

   // ************************************************************
   // command sequencer: load, then back-to-back advances
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         la_r     <= 1'b0;
         wn_r     <= 1'b1;
         s1n_r    <= 1'b1;
         be_r     <= '1;
         caddr_r  <= '0;
         beats_r  <= 2'h0;
         act_rd_r <= 1'b0;
         act_wr_r <= 1'b0;
      end
      else if (issue)
      begin
         la_r     <= 1'b0;                                    // (R11)
         wn_r     <= (kind != ssb_pkg::KIND_WRITE);
         s1n_r    <= (kind == ssb_pkg::KIND_DESEL);
         be_r     <= pwdata[ssb_pkg::CMD_BE +: LANES];
         caddr_r  <= addr_r;
         beats_r  <= pwdata[ssb_pkg::CMD_BEATS +: 2];
         act_rd_r <= (kind == ssb_pkg::KIND_READ);
         act_wr_r <= (kind == ssb_pkg::KIND_WRITE);
      end
      else if (run)
      begin
         if (beats_r != 2'h0)
         begin
            // deselect continue follows only its own deselect
            la_r    <= 1'b1;                                  // (R17)
            beats_r <= 2'(beats_r - 2'h1);
         end
         else
         begin
            la_r     <= 1'b0;
            wn_r     <= 1'b1;
            s1n_r    <= 1'b1;
            act_rd_r <= 1'b0;
            act_wr_r <= 1'b0;
         end
      end
   end

   // ************************************************************
   // data slots
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         p1_rd_r <= 1'b0;
         p1_wr_r <= 1'b0;
         p2_rd_r <= 1'b0;
         p2_wr_r <= 1'b0;
         hoe_r   <= 1'b0;
         hdq_r   <= '0;
      end
      else if (run)
      begin
         p1_rd_r <= act_rd_r;
         p1_wr_r <= act_wr_r;
         p2_rd_r <= p1_rd_r;
         p2_wr_r <= p1_wr_r;
         // drive across the edge the sram takes the data on
         hoe_r   <= flow ? act_wr_r : p1_wr_r;                // (R7) (R9)
         hdq_r   <= wdata_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rdata_r <= '0;
         done_r  <= 1'b0;
      end
      else if (capture)
      begin
         rdata_r <= bus.dq;
         done_r  <= 1'b1;
      end
      else if (issue)
      begin
         done_r  <= 1'b0;
      end
   end

   assign bus.cke_n                = ctrl_r[ssb_pkg::CTRL_HOLD];
   assign bus.load_advance         = la_r;
   assign bus.write_n              = wn_r;
   assign bus.byte_lane_write_n    = be_r;
   assign bus.select_first_n       = s1n_r;
   assign bus.select_second        = 1'b1;
   assign bus.select_third_n       = 1'b0;
   assign bus.out_enable_n         = ctrl_r[ssb_pkg::CTRL_OE_N];
   assign bus.sleep_request        = ctrl_r[ssb_pkg::CTRL_SLEEP];
   assign bus.burst_order_select   = ctrl_r[ssb_pkg::CTRL_ORDER];
   assign bus.output_register_mode = ctrl_r[ssb_pkg::CTRL_PIPE];
   assign bus.addr                 = caddr_r;
   assign bus.host_dq_o            = hdq_r;
   assign bus.host_dq_oe           = hoe_r;
   assign prdata                   = prdata_r;
   assign pready                   = pready_r;
   assign pslverr                  = pslverr_r;

endmodule // ssb_host

// ---- tb/ssb_link_chk.sv ----
// assertions on the burst sram pin link
`timescale 1ns/100ps
module ssb_link_chk (
   // clock and reset
   input wire logic       pclk,
   input wire logic       presetn,
   // link pins
   input wire logic       cke_n,
   input wire logic       load_advance,
   input wire logic       write_n,
   input wire logic [3:0] byte_lane_write_n,
   input wire logic       select_first_n,
   input wire logic       select_second,
   input wire logic       select_third_n,
   input wire logic       out_enable_n,
   input wire logic       sleep_request,
   input wire logic       output_register_mode,
   input wire logic       dev_dq_oe,
   input wire logic       host_dq_oe
);
   // ******
   // command decode
   // ******
   logic [2:0] zz_r;
   logic       sel;
   logic       live;
   logic       rd;
   logic       wr;
   // one sample wider than the wake-up window
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         zz_r <= 3'h0;
      else
         zz_r <= {zz_r[1:0], sleep_request};
   assign sel  = ~select_first_n & select_second & ~select_third_n;
   assign live = ~cke_n & ~sleep_request & (zz_r == 3'h0);
   assign rd   = live & ~load_advance & sel & write_n & ~out_enable_n;
   assign wr   = live & ~load_advance & sel & ~write_n
                 & (byte_lane_write_n != 4'hf);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_rd_p; rd && output_register_mode ##1 live; endsequence
   sequence s_wr_p; wr && output_register_mode ##1 live; endsequence
   sequence s_wr_f;
      wr && !output_register_mode ##1 !load_advance && !cke_n;
   endsequence
   // ******
   // checks
   // ******
   no_clash_a: assert property (
      !(dev_dq_oe && host_dq_oe)) else $error("both ends drive data");
   stall_hold_a: assert property (
      cke_n && !sleep_request |=> $stable(dev_dq_oe))
      else $error("stall moved the drive enable");
   pipe_read_a: assert property (s_rd_p |=> dev_dq_oe)
      else $error("pipelined read data missing");
   flow_read_a: assert property (
      rd && !output_register_mode |=> dev_dq_oe)
      else $error("flow read data missing");
   write_off_a: assert property (s_wr_p |=> !dev_dq_oe)
      else $error("device drives during write");
   pipe_wdata_a: assert property (s_wr_p |=> host_dq_oe)
      else $error("pipelined write data not presented");
   flow_wdata_a: assert property (
      s_wr_f |-> host_dq_oe ##1 !host_dq_oe)
      else $error("flow write data slot wrong");
   sleep_off_a: assert property (sleep_request |=> !dev_dq_oe)
      else $error("device drives while asleep");
   reset_float_a: assert property ($rose(presetn) |-> !dev_dq_oe)
      else $error("device drives after reset");
endmodule // ssb_link_chk

// ---- tb/testbench.sv ----
// self-checking bench for the controller and device pair
`timescale 1ns/100ps
module testbench;
   // ******
   // signals and instances
   // ******
   typedef struct packed {
      logic [4:0] ctrl;
      logic [7:0] start;
      logic [1:0] beats;
      logic [3:0] hit;
   } ssb_row_t;
   localparam logic [35:0] MARK  = 36'h3_5a5a_0001;
   localparam logic [35:0] DATA  = 36'h9_c3a5_96e1;
   localparam logic [35:0] LANE1 = 36'h0_0003_fe00;
   ssb_row_t    rows [4] = '{'{5'h02, 8'h13, 2'h1, 4'h9},
      '{5'h03, 8'h11, 2'h2, 4'hb}, '{5'h00, 8'h22, 2'h3, 4'hf},
      '{5'h01, 8'h22, 2'h0, 4'h4}};
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        asleep;
   logic        access;
   logic [31:0] q;
   logic [35:0] v;
   logic        err;
   int          error_cnt   = 0;
   int          checks_done = 0;
   always #5 pclk = ~pclk;
   ssb_if link ();
   ssb_dev ssb_dev_inst (.pclk(pclk), .presetn(presetn), .bus(link),
      .asleep(asleep), .access(access));
   ssb_host ssb_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(link));
   ssb_link_chk ssb_link_chk_inst (.pclk(pclk), .presetn(presetn),
      .cke_n(link.cke_n), .load_advance(link.load_advance),
      .write_n(link.write_n), .byte_lane_write_n(link.byte_lane_write_n),
      .select_first_n(link.select_first_n),
      .select_second(link.select_second),
      .select_third_n(link.select_third_n),
      .out_enable_n(link.out_enable_n), .sleep_request(link.sleep_request),
      .output_register_mode(link.output_register_mode),
      .dev_dq_oe(link.dev_dq_oe), .host_dq_oe(link.host_dq_oe));
   // ******
   // tasks
   // ******
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic guard(input int n);
      if (n > 30)
      begin
         error_cnt++;
         summarize();
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         guard(++n);
         @(posedge pclk);
      end
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic ctl(input logic [4:0] c);
      apb(1'b1, ssb_pkg::REG_CTRL, {27'h0, c});
   endtask
   task automatic cmd(input logic [1:0] k, input logic [1:0] b,
                      input logic [3:0] be);
      int n;
      n = 0;
      apb(1'b1, ssb_pkg::REG_CMD, {24'h0, be, b, k});
      do
      begin
         guard(++n);
         apb(1'b0, ssb_pkg::REG_STATUS, 32'h0);
      end
      while (q[0] !== 1'b0 || (k == ssb_pkg::KIND_READ && q[1] !== 1'b1));
   endtask
   task automatic put(input logic [7:0] a, input logic [35:0] d,
                      input logic [3:0] be, input logic [1:0] b);
      apb(1'b1, ssb_pkg::REG_ADDR, {24'h0, a});
      apb(1'b1, ssb_pkg::REG_WDATA, d[31:0]);
      apb(1'b1, ssb_pkg::REG_WDATA_HI, {28'h0, d[35:32]});
      cmd(ssb_pkg::KIND_WRITE, b, be);
   endtask
   task automatic get(input logic [7:0] a);
      apb(1'b1, ssb_pkg::REG_ADDR, {24'h0, a});
      cmd(ssb_pkg::KIND_READ, 2'h0, 4'hf);
      apb(1'b0, ssb_pkg::REG_RDATA_HI, 32'h0);
      v[35:32] = q[3:0];
      apb(1'b0, ssb_pkg::REG_RDATA, 32'h0);
      v[31:0] = q;
   endtask
   // ******
   // main sequence
   // ******
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(link.dev_dq_oe, 1'b0);
      apb(1'b0, ssb_pkg::REG_CTRL, 32'h0);
      chk(q, 32'h2);
      foreach (rows[i])
      begin
         ctl(rows[i].ctrl);
         for (int j = 0; j < 4; j++)
            put({rows[i].start[7:2], 2'(j)}, MARK, 4'h0, 2'h0);
         put(rows[i].start, DATA, 4'h0, rows[i].beats);
         for (int j = 0; j < 4; j++)
         begin
            get({rows[i].start[7:2], 2'(j)});
            chk(v, rows[i].hit[j] ? DATA : MARK);
         end
         $display("burst row %0d done", i);
      end
      ctl(5'h2);
      put(8'h40, MARK, 4'h0, 2'h0);
      put(8'h40, DATA, 4'hd, 2'h0);
      put(8'h40, 36'h0, 4'hf, 2'h0);
      get(8'h40);
      chk(v, (MARK & ~LANE1) | (DATA & LANE1));
      $display("byte lane test done");
      ctl(5'ha);
      get(8'h40);
      chk(v, 36'h0);
      ctl(5'h12);
      repeat (3) @(posedge pclk);
      ctl(5'h2);
      apb(1'b0, 8'h20, 32'h0);
      chk({err, q}, 33'h1_0000_0000);
      $display("misc tests done");
      ctl(5'h6);
      #1;
      chk(asleep, 1'b0);
      repeat (3) @(posedge pclk);
      #1;
      chk(asleep, 1'b1);
      chk(link.dq, 36'h0);
      ctl(5'h2);
      repeat (4) @(posedge pclk);
      get(8'h40);
      chk(v, (MARK & ~LANE1) | (DATA & LANE1));
      $display("sleep test done");
      ctl(5'h3);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, ssb_pkg::REG_CTRL, 32'h0);
      chk(q, 32'h2);
      $display("second reset test done");
      summarize();
   end
endmodule // testbench
